// [pkg/snvm_defines.vh]
// Constants shared by the serial byte memory design
`ifndef SNVM_DEFINES_VH
`define SNVM_DEFINES_VH

// Array geometry
`define SNVM_ADDR_W 11
`define SNVM_DATA_W 8
`define SNVM_MEM_DEPTH 2048
`define SNVM_PAGE_W 3
`define SNVM_ADDR_ZERO 11'h000
`define SNVM_ADDR_ONE 11'h001

// Fields of the first byte after a start
`define SNVM_DA_TYPE_HI 7
`define SNVM_DA_TYPE_LO 4
`define SNVM_DA_PAGE_HI 3
`define SNVM_DA_PAGE_LO 1
`define SNVM_DA_RW 0

// Device type code; value is arbitrary
`define SNVM_DEV_TYPE 4'h5

// Bit counter points: last data bit and acknowledge slot
`define SNVM_BIT_ZERO 4'h0
`define SNVM_BIT_ONE 4'h1
`define SNVM_BIT_LAST 4'h7
`define SNVM_BIT_ACK 4'h8
`define SNVM_BIT_MSB 7

// Write buffer shape
`define SNVM_FIFO_DEPTH 16
`define SNVM_FIFO_AW 4

// Timing: fastest bus clock against the 50 MHz system clock
`define SNVM_CLK_KHZ 50000
`define SNVM_SCL_MAX_KHZ 1000
`define SNVM_SCL_MIN_CYC (`SNVM_CLK_KHZ / `SNVM_SCL_MAX_KHZ)

`endif

// [rtl/snvm_top.v]
// Two-wire serial target with a 2048 x 8 byte array and its write buffer
`timescale 1ns/1ps
`include "snvm_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Write buffer: flip-flop FIFO, valid/ready on both sides
module snvm_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage carries no reset; only pointers and count matter
  always @(posedge clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // snvm_fifo

////////////////////////////////////////////////////////////////////////////////
// Contract
// - The array holds 2048 locations of eight bits, each reachable by an eleven-bit location.
// - Each fully received data byte, with the write-lock input low and room in the buffer, is queued there and committed to the array one or more cycles later.
// - There is never a busy state after a write, so a new transaction is taken at once.
// - Serial data is sampled on the rising bus clock edge and changed on the falling edge.
// - With the write-lock input high no location of the array is modified.
// - With the write-lock input low every location may be written.
// - The data line is only pulled low or released, never driven high.
// - The bus clock may run up to 1 MHz and also at 100 kHz and 400 kHz.
// - The first byte carries a four-bit type code, a page select in bits 3 to 1 and direction in bit 0.
// - A write sends a word-address byte that joins the page select into an eleven-bit location.
// - The location advances after each data byte before its acknowledge and wraps from the top to zero.
// - A read takes no word address, latches the new page and returns data starting at the latched location.
module snvm_top (
  // System clock and reset
  input wire clk,
  input wire nrst,
  // Serial bus pins, data as open-drain triple
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n,
  // Write-lock pin
  input wire wr_lock_i
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_DEV = 5'b00010;
  localparam ST_WADDR = 5'b00100;
  localparam ST_WDATA = 5'b01000;
  localparam ST_RDATA = 5'b10000;
  localparam FW = `SNVM_ADDR_W + `SNVM_DATA_W;

  // Pin synchronisers; stage one feeds only stage two
  reg scl_m_reg;
  reg scl_s_reg;
  reg scl_d_reg;
  reg sda_m_reg;
  reg sda_s_reg;
  reg sda_d_reg;
  reg lock_m_reg;
  reg lock_s_reg;
  // Protocol state
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [4:0] pend_reg;
  reg [4:0] pend_next;
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [7:0] tx_reg;
  reg [7:0] tx_next;
  reg [`SNVM_ADDR_W-1:0] addr_reg;
  reg [`SNVM_ADDR_W-1:0] addr_next;
  reg [`SNVM_PAGE_W-1:0] page_reg;
  reg [`SNVM_PAGE_W-1:0] page_next;
  reg ack_go_reg;
  reg ack_go_next;
  reg oe_n_reg;
  reg oe_n_next;
  reg push_req;
  // Array and buffer wiring
  reg [`SNVM_DATA_W-1:0] mem [0:`SNVM_MEM_DEPTH-1];
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [7:0] byte_in;
  wire fill_ready;
  wire drain_valid;
  wire drain_ready;
  wire [FW-1:0] drain_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers plus one delay stage for edge finding
  always @(posedge clk) begin
    if (!nrst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      lock_m_reg <= 1'b0;
      lock_s_reg <= 1'b0;
    end else begin
      scl_m_reg <= scl_i;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      lock_m_reg <= wr_lock_i;
      lock_s_reg <= lock_m_reg;
    end
  end

  // Bus events; a 1 MHz clock leaves about 25 system cycles per phase
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign bus_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign bus_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign byte_in = {shift_reg[6:0], sda_s_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine: samples on rising edges, drives on falling edges
  always @* begin
    state_next = state_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    page_next = page_reg;
    ack_go_next = ack_go_reg;
    oe_n_next = oe_n_reg;
    push_req = 1'b0;
    if (bus_start) begin
      // Abort anything in flight and expect the address byte
      state_next = ST_DEV;
      cnt_next = `SNVM_BIT_ZERO;
      ack_go_next = 1'b0;
      oe_n_next = 1'b1;
    end else if (bus_stop) begin
      state_next = ST_IDLE;
      ack_go_next = 1'b0;
      oe_n_next = 1'b1;
    end else if (scl_rise && state_reg != ST_IDLE) begin
      if (cnt_reg != `SNVM_BIT_ACK) begin
        shift_next = byte_in;
        cnt_next = cnt_reg + `SNVM_BIT_ONE;
      end else begin
        cnt_next = `SNVM_BIT_ZERO;
        ack_go_next = 1'b0;
        state_next = pend_reg;
        // Master answer after a read byte: high means stop sending
        if (state_reg == ST_RDATA && sda_s_reg) begin
          state_next = ST_IDLE;
        end
        if (state_next == ST_RDATA) begin
          tx_next = mem[addr_reg];
        end
      end
      if (cnt_reg == `SNVM_BIT_LAST) begin
        case (state_reg)
          ST_DEV: begin
            if (byte_in[`SNVM_DA_TYPE_HI:`SNVM_DA_TYPE_LO] == `SNVM_DEV_TYPE) begin
              page_next = byte_in[`SNVM_DA_PAGE_HI:`SNVM_DA_PAGE_LO];
              ack_go_next = 1'b1;
              if (byte_in[`SNVM_DA_RW]) begin
                // No word address on reads, keep the low eight bits
                addr_next = {byte_in[`SNVM_DA_PAGE_HI:`SNVM_DA_PAGE_LO], addr_reg[7:0]};
                pend_next = ST_RDATA;
              end else begin
                pend_next = ST_WADDR;
              end
            end else begin
              state_next = ST_IDLE;
            end
          end
          ST_WADDR: begin
            addr_next = {page_reg, byte_in};
            ack_go_next = 1'b1;
            pend_next = ST_WDATA;
          end
          ST_WDATA: begin
            if (fill_ready) begin
              // Locked writes are still acknowledged but dropped
              push_req = ~lock_s_reg;
              addr_next = addr_reg + `SNVM_ADDR_ONE;
              ack_go_next = 1'b1;
              pend_next = ST_WDATA;
            end else begin
              pend_next = ST_IDLE;
            end
          end
          ST_RDATA: begin
            addr_next = addr_reg + `SNVM_ADDR_ONE;
            pend_next = ST_RDATA;
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end
    end else if (scl_fall && state_reg != ST_IDLE) begin
      // Apart from the release on a start or stop, output changes only here, so it is stable while the clock is high
      if (cnt_reg == `SNVM_BIT_ACK) begin
        oe_n_next = ~ack_go_reg;
      end else if (state_reg == ST_RDATA) begin
        oe_n_next = tx_reg[`SNVM_BIT_MSB - cnt_reg[2:0]];
      end else begin
        oe_n_next = 1'b1;
      end
    end
  end

  // Protocol registers
  always @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      pend_reg <= ST_IDLE;
      cnt_reg <= `SNVM_BIT_ZERO;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= `SNVM_ADDR_ZERO;
      page_reg <= {`SNVM_PAGE_W{1'b0}};
      ack_go_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      page_reg <= page_next;
      ack_go_reg <= ack_go_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Open drain: the level driven is always low, only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Write buffer between the byte engine and the array
  snvm_fifo #(
    .WIDTH(FW),
    .DEPTH(`SNVM_FIFO_DEPTH),
    .AW(`SNVM_FIFO_AW)
  ) u_wbuf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_req),
    .in_ready(fill_ready),
    .in_data({addr_reg, byte_in}),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data)
  );

  // Array fetches on ack-slot rises take the port; draining waits one cycle
  assign drain_ready = ~(scl_rise & (cnt_reg == `SNVM_BIT_ACK));

  // Array write port, drains long before the next byte completes
  always @(posedge clk) begin
    if (drain_valid && drain_ready) begin
      mem[drain_data[FW-1:`SNVM_DATA_W]] <= drain_data[`SNVM_DATA_W-1:0];
    end
  end

endmodule // snvm_top

// [test/snvm_asserts.sv]
// Pin-level checker for the serial byte memory
`timescale 1ns/1ps
`include "snvm_defines.vh"
module snvm_asserts (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Bus and lock pins
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_n,
  input wire wr_lock_i
);
  logic scl_reg;
  logic [3:0] bits_reg;
  logic [7:0] dev_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Counts clock rises after each start and keeps the first byte
  always @(posedge clk) begin
    scl_reg <= scl_i;
    if (!nrst || (scl_i && scl_reg && $fell(sda_i))) begin
      bits_reg <= 4'h0;
    end else if (scl_i && !scl_reg && bits_reg != 4'hf) begin
      bits_reg <= bits_reg + 4'h1;
      if (bits_reg < 4'h8) begin
        dev_reg <= {dev_reg[6:0], sda_i};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  sequence s_ninth;
    scl_i && !scl_reg && bits_reg == 4'h8;
  endsequence
  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  property p_pull_after_fall;
    $fell(sda_oe_n) |-> !scl_i && !$past(scl_i, 2) && $past(scl_i, 6);
  endproperty
  // Four samples fit in one 80 ns high phase; first and last must agree
  property p_steady_high;
    scl_i && $past(scl_i, 3) && $past(sda_i, 3) == sda_i |-> $past(sda_oe_n, 3) == sda_oe_n;
  endproperty
  property p_stop_idle;
    s_stop |-> ##4 sda_oe_n [*8];
  endproperty
  property p_start_idle;
    s_start |-> ##4 sda_oe_n [*8];
  endproperty
  property p_addr_quiet;
    bits_reg > 4'h0 && bits_reg < 4'h8 |-> sda_oe_n;
  endproperty
  property p_type_ack;
    s_ninth |-> sda_oe_n == (dev_reg[7:4] != `SNVM_DEV_TYPE);
  endproperty
  // Answer holds through the high phase and until the release after the next fall
  property p_ack_stands;
    s_ninth ##0 !sda_oe_n |-> !sda_oe_n [*7];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_pull_after_fall: assert property (p_pull_after_fall) else $error("pull not after clock fall");
  a_steady_high: assert property (p_steady_high) else $error("output moved in high phase");
  a_stop_idle: assert property (p_stop_idle) else $error("line held after stop");
  a_start_idle: assert property (p_start_idle) else $error("line held after start");
  a_addr_quiet: assert property (p_addr_quiet) else $error("line pulled in first byte");
  a_type_ack: assert property (p_type_ack) else $error("wrong first byte answer");
  a_ack_stands: assert property (p_ack_stands) else $error("answer dropped early");
endmodule // snvm_asserts

// [test/snvm_master.sv]
// Bus controller model that drives the serial clock and data lines
`timescale 1ns/1ps
module snvm_master (
  // Bus pins; sda is the wire level
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Idle bus: both lines released to the pull-up level
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One bit in a 160 ns clock period; data moves mid-low, is read mid-high
  // Every step is two system clocks, so the pins stay on falling clock edges
  task automatic bit_x(input logic b, output logic s);
    #40 sda_m = b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask
  // Start, also a repeated start from a low clock
  task automatic start_c();
    #40 sda_m = 1'b1;
    #40 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl = 1'b0;
  endtask
  // Stop, then a short idle gap
  task automatic stop_c();
    #40 sda_m = 1'b0;
    #40 scl = 1'b1;
    #40 sda_m = 1'b1;
    #80;
  endtask
  // Byte out most significant bit first, returns the acknowledge level
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], x);
    end
    bit_x(1'b1, ack_n);
  endtask
  // Byte in; acknowledged unless it is the last one
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, x);
  endtask
endmodule // snvm_master

// [test/snvm_top_tb.sv]
// Self-checking bench for the serial byte memory
`timescale 1ns/1ps
`include "snvm_defines.vh"
module snvm_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_lock = 1'b0;
  wire logic scl, sda_m, sda_o, sda_oe_n, sda;
  logic [7:0] mem_m [0:2047];
  logic [10:0] ptr;
  int num_errors = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  // Pull-up: a released line reads high
  assign sda = !sda_oe_n ? sda_o : sda_m;
  snvm_top dut_u (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .wr_lock_i(wr_lock));
  snvm_master mst_u (.scl(scl), .sda_m(sda_m), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev_byte(input logic [2:0] page, input logic rd);
    return {`SNVM_DEV_TYPE, page, rd};
  endfunction
  // Write n random bytes from loc; a locked write leaves the model as it was
  task automatic wr_seq(input logic [10:0] loc, input int n);
    logic a;
    logic [7:0] d;
    mst_u.start_c();
    mst_u.put_byte(dev_byte(loc[10:8], 1'b0), a);
    check({7'h0, a}, 8'h00);
    mst_u.put_byte(loc[7:0], a);
    check({7'h0, a}, 8'h00);
    ptr = loc;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      mst_u.put_byte(d, a);
      check({7'h0, a}, 8'h00);
      if (!wr_lock) mem_m[ptr] = d;
      ptr = ptr + 11'h1;
    end
  endtask
  // Read n bytes from the new page at the latched low address
  task automatic rd_seq(input logic [2:0] page, input int n);
    logic a;
    logic [7:0] d;
    mst_u.start_c();
    mst_u.put_byte(dev_byte(page, 1'b1), a);
    check({7'h0, a}, 8'h00);
    ptr = {page, ptr[7:0]};
    for (int i = 0; i < n; i++) begin
      mst_u.get_byte(i == n - 1, d);
      check(d, mem_m[ptr]);
      ptr = ptr + 11'h1;
    end
    mst_u.stop_c();
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; bus pins move only on falling clock edges
  initial begin
    logic a;
    logic [10:0] loc;
    loc = 11'($urandom(32'hfc27e7a9));
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (int t = 0; t < 4; t++) begin
      loc = 11'($urandom);
      wr_seq(loc, 3);
      mst_u.stop_c();
      wr_seq(loc, 0);
      rd_seq(loc[10:8], 3);
      $display("test random_rw %0d done", t);
    end
    wr_seq(11'h7ff, 2);
    mst_u.stop_c();
    wr_seq(11'h7ff, 0);
    rd_seq(3'h7, 2);
    $display("test wrap done");
    @(negedge clk) wr_lock = 1'b1;
    wr_seq(loc, 3);
    mst_u.stop_c();
    @(negedge clk) wr_lock = 1'b0;
    wr_seq(loc, 0);
    rd_seq(loc[10:8], 3);
    $display("test lock done");
    for (int k = 0; k < 16; k++) begin
      mst_u.start_c();
      mst_u.put_byte({4'(k), 3'h2, 1'b0}, a);
      check({7'h0, a}, {7'h0, 4'(k) != `SNVM_DEV_TYPE});
      mst_u.stop_c();
    end
    $display("test type done");
    // Half a data byte, then a start: nothing may be written
    wr_seq(loc, 0);
    for (int i = 0; i < 4; i++) mst_u.bit_x(~mem_m[loc][7 - i], a);
    mst_u.start_c();
    mst_u.stop_c();
    wr_seq(loc, 0);
    rd_seq(loc[10:8], 1);
    $display("test abort done");
    final_report();
  end
  // Watchdog against a hung bus
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule // snvm_top_tb
bind snvm_top snvm_asserts snvm_chk (.clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .wr_lock_i(wr_lock_i));
